//--- hw/kpe_top.sv
// keypad front end: parameter value editing and test-running commands
// assumes keys and status inputs synchronous to i_core_clk, keys not yet debounced
`timescale 1ns/100ps
module kpe_top
  import kpe_pkg::*;
#(
  parameter int P_DEB_CYC   = DEB_CYC,
  parameter int P_LONG_CYC  = LONG_CYC,
  parameter int P_BLINK_CYC = EDIT_HALF_CYC,
  parameter int P_STORE_CYC = STORE_HALF_CYC
) (
  // clock and reset
  input  wire  logic               i_core_clk,
  input  wire  logic               i_rst_b,
  // keys
  input  wire  logic               i_key_up,
  input  wire  logic               i_key_down,
  input  wire  logic               i_key_shift,
  input  wire  logic               i_key_enter,
  input  wire  logic               i_key_esc,
  input  wire  logic               i_test_mode,
  // parameter store
  input  wire  logic [19:0]        i_param_bcd,
  input  wire  logic               i_param_neg,
  input  wire  logic [2:0]         i_param_digits,
  input  wire  logic               i_param_signed,
  input  wire  logic signed [17:0] i_range_min,
  input  wire  logic signed [17:0] i_range_max,
  input  wire  logic               i_write_protect,
  // servo core status
  input  wire  logic               i_run,
  input  wire  logic               i_forward_run_command,
  input  wire  logic               i_reverse_run_command,
  input  wire  logic               i_motor_rotating,
  input  wire  logic               i_forced_stop,
  input  wire  logic               i_regen_overheat,
  input  wire  logic               i_overtravel_limit_fwd,
  input  wire  logic               i_overtravel_limit_rev,
  input  wire  logic               i_coast,
  input  wire  logic [14:0]        i_alarm_evt,
  input  wire  logic [15:0]        i_feed_speed,
  input  wire  logic [15:0]        i_vref_offset,
  input  wire  logic [17:0]        i_z_distance,
  // display
  output logic [11:0]              o_disp_digits,
  output logic [1:0]               o_disp_marker,
  output logic [2:0]               o_blink_mask,
  output logic                     o_rejection_indication,
  output logic [6:0]               o_param_num,
  output logic [3:0]               o_fn_num,
  // parameter write
  output logic                     o_wr_stb,
  output logic [6:0]               o_wr_addr,
  output logic [17:0]              o_wr_data,
  // servo core commands
  output logic                     o_feed_fwd,
  output logic                     o_feed_rev,
  output logic [15:0]              o_feed_speed,
  output logic                     o_test_stop,
  output logic                     o_cmd_pos_clr,
  output logic                     o_fb_pos_clr,
  output logic                     o_cmd_cum_clr,
  output logic                     o_fb_cum_clr,
  output logic [14:0]              o_alarm,
  output logic                     o_hist_erase,
  output logic                     o_param_init
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    kpe_state_t       st;
    logic [4:0]       key;
    logic [4:0][19:0] deb;
    logic [26:0]      lp_cnt;
    logic             lp_done;
    logic [26:0]      blk_cnt;
    logic             blk_ph;
    logic [26:0]      st_cnt;
    logic [2:0]       st_ph;
    logic [6:0]       pnum;
    logic [3:0]       fn;
    logic [4:0][3:0]  dig;
    logic             neg;
    logic [2:0]       ndig;
    logic             sgn;
    logic [1:0]       sel;
    logic             upper;
    logic             rej;
    logic [11:0]      disp;
    kpe_marker_t      mark;
    logic [2:0]       blank;
    logic             wr_stb;
    logic [6:0]       wr_addr;
    logic [17:0]      wr_data;
    logic             feed_fwd;
    logic             feed_rev;
    logic [15:0]      feed_speed;
    logic             test_stop;
    logic             pos_clr;
    logic             cum_clr;
    logic [14:0]      alarm;
    logic             hist_erase;
    logic             param_init;
  } kpe_regs_t;

  localparam logic [19:0] DEB_LAST   = 20'(P_DEB_CYC - 1);
  localparam logic [26:0] LONG_LAST  = 27'(P_LONG_CYC - 1);
  localparam logic [26:0] BLINK_LAST = 27'(P_BLINK_CYC - 1);
  localparam logic [26:0] STORE_LAST = 27'(P_STORE_CYC - 1);

  kpe_regs_t          r;
  kpe_regs_t          next_r;
  logic               rst_meta;
  logic               rst_n;
  logic [4:0]         raw;
  logic [4:0]         press;
  logic [14:0]        alm_clr;
  logic               lp_evt;
  logic               busy;
  logic               split;
  logic               inhibit;
  logic [1:0]         smax;
  logic [2:0]         didx;
  logic signed [17:0] val;
  logic               in_rng;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [3:0] dstep(input logic [3:0] d, input logic up);
    if (up) begin
      dstep = (d >= DIGIT_MAX) ? 4'h0 : d + 4'h1;
    end else begin
      dstep = (d == 4'h0) ? DIGIT_MAX : d - 4'h1;
    end
  endfunction

  function automatic logic [16:0] bcd2bin(input logic [4:0][3:0] d);
    bcd2bin = 17'(d[4]) * 17'd10000 + 17'(d[3]) * 17'd1000 + 17'(d[2]) * 17'd100
            + 17'(d[1]) * 17'd10 + 17'(d[0]);
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  assign raw     = {i_key_esc, i_key_enter, i_key_shift, i_key_down, i_key_up};
  assign lp_evt  = r.key[K_ENT] & ~r.lp_done & (r.lp_cnt == LONG_LAST);
  assign busy    = (i_run & (i_forward_run_command | i_reverse_run_command)) | i_motor_rotating;
  assign split   = r.ndig > HALF_DIGITS;
  assign inhibit = i_forced_stop | i_regen_overheat | i_coast;
  assign smax    = split ? 2'h2 : ((r.ndig == 3'h0) ? 2'h0 : 2'(r.ndig - 3'h1));
  assign didx    = (r.upper ? 3'h2 : 3'h0) + {1'b0, r.sel};
  assign val     = r.neg ? -$signed({1'b0, bcd2bin(r.dig)}) : $signed({1'b0, bcd2bin(r.dig)});
  assign in_rng  = (val >= i_range_min) && (val <= i_range_max);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r            = r;
    press             = 5'h00;
    alm_clr           = 15'h0000;
    next_r.wr_stb     = 1'b0;
    next_r.pos_clr    = 1'b0;
    next_r.cum_clr    = 1'b0;
    next_r.hist_erase = 1'b0;
    next_r.param_init = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (raw[i] != r.key[i]) begin
        next_r.deb[i] = r.deb[i] + 20'h1;
        if (r.deb[i] == DEB_LAST) begin
          next_r.key[i] = raw[i];
          next_r.deb[i] = 20'h0;
        end
      end else begin
        next_r.deb[i] = 20'h0;
      end
    end
    press = next_r.key & ~r.key;
    if (r.key[K_ENT]) begin
      next_r.lp_cnt = r.lp_done ? r.lp_cnt : r.lp_cnt + 27'h1;
      if (lp_evt) begin
        next_r.lp_done = 1'b1;
        next_r.lp_cnt  = 27'h0;
      end
    end else begin
      next_r.lp_cnt  = 27'h0;
      next_r.lp_done = 1'b0;
    end
    next_r.blk_cnt = r.blk_cnt + 27'h1;
    if (r.blk_cnt == BLINK_LAST) begin
      next_r.blk_cnt = 27'h0;
      next_r.blk_ph  = ~r.blk_ph;
    end
    if (|press) begin
      next_r.rej = 1'b0;
    end
    case (r.st)
      KPE_PSEL: begin
        if (press[K_UP]) begin
          next_r.pnum = (r.pnum >= PARAM_LAST) ? 7'h00 : r.pnum + 7'h01;
        end else if (press[K_DN]) begin
          next_r.pnum = (r.pnum == 7'h00) ? PARAM_LAST : r.pnum - 7'h01;
        end else if (lp_evt) begin
          next_r.dig     = i_param_bcd;
          next_r.neg     = i_param_neg;
          next_r.ndig    = i_param_digits;
          next_r.sgn     = i_param_signed;
          next_r.sel     = 2'h0;
          next_r.upper   = i_param_digits > HALF_DIGITS;
          next_r.blk_cnt = 27'h0;
          next_r.blk_ph  = 1'b0;
          next_r.st      = KPE_EDIT;
        end
      end
      KPE_EDIT: begin
        if (press[K_ESC]) begin
          next_r.st = KPE_PSEL;
        end else if (lp_evt) begin
          if (in_rng) begin
            next_r.wr_stb  = 1'b1;
            next_r.wr_addr = r.pnum;
            next_r.wr_data = val;
            next_r.st_cnt  = 27'h0;
            next_r.st_ph   = 3'h0;
            next_r.st      = KPE_STORE;
          end else begin
            next_r.rej = 1'b1;
          end
        end else if (press[K_UP] | press[K_DN]) begin
          next_r.dig[didx] = dstep(r.dig[didx], press[K_UP]);
        end else if (press[K_SH]) begin
          if (r.sel == smax) begin
            next_r.sel   = 2'h0;
            next_r.upper = split & ~r.upper;
          end else begin
            next_r.sel = r.sel + 2'h1;
          end
        end
      end
      KPE_STORE: begin
        next_r.st_cnt = r.st_cnt + 27'h1;
        if (press[K_ESC]) begin
          next_r.st = KPE_PSEL;
        end else if (r.st_cnt == STORE_LAST) begin
          next_r.st_cnt = 27'h0;
          next_r.st_ph  = r.st_ph + 3'h1;
          if (r.st_ph == STORE_PHASES) begin
            next_r.st = KPE_EDIT;
          end
        end
      end
      KPE_TMENU: begin
        if (press[K_UP]) begin
          next_r.fn = (r.fn >= FN_ZADJ) ? FN_FEED : r.fn + 4'h1;
        end else if (press[K_DN]) begin
          next_r.fn = (r.fn <= FN_FEED) ? FN_ZADJ : r.fn - 4'h1;
        end else if (lp_evt) begin
          case (r.fn)
            FN_FEED: begin
              next_r.rej = busy;
              next_r.st  = busy ? KPE_TMENU : KPE_FEED;
            end
            FN_POS: begin
              next_r.rej     = busy;
              next_r.pos_clr = ~busy;
            end
            FN_CUM: begin
              next_r.rej     = busy;
              next_r.cum_clr = ~busy;
            end
            FN_ALM: begin
              alm_clr = ALM_RESET_MASK;
            end
            FN_HIST: begin
              next_r.hist_erase = 1'b1;
            end
            FN_PINIT: begin
              next_r.rej        = i_run | i_write_protect;
              next_r.param_init = ~(i_run | i_write_protect);
            end
            FN_OFS: begin
              next_r.rej     = i_write_protect;
              next_r.wr_stb  = ~i_write_protect;
              next_r.wr_addr = PARAM_OFS;
              next_r.wr_data = {{2{i_vref_offset[15]}}, i_vref_offset};
            end
            FN_ZADJ: begin
              next_r.wr_stb  = 1'b1;
              next_r.wr_addr = PARAM_ZOFS;
              next_r.wr_data = i_z_distance;
            end
            default: begin
              next_r.fn = FN_FEED;
            end
          endcase
        end
      end
      KPE_FEED: begin
        if (press[K_ESC]) begin
          next_r.st = KPE_TMENU;
        end
      end
      default: begin
        next_r.st = KPE_PSEL;
      end
    endcase
    if (i_test_mode && (r.st == KPE_PSEL || r.st == KPE_EDIT || r.st == KPE_STORE)) begin
      next_r.st = KPE_TMENU;
    end else if (!i_test_mode && (r.st == KPE_TMENU || r.st == KPE_FEED)) begin
      next_r.st = KPE_PSEL;
    end
    next_r.alarm      = (r.alarm & ~alm_clr) | i_alarm_evt;
    next_r.feed_speed = i_feed_speed;
    next_r.feed_fwd   = (r.st == KPE_FEED) & r.key[K_UP] & ~inhibit & ~i_overtravel_limit_fwd;
    next_r.feed_rev   = (r.st == KPE_FEED) & r.key[K_DN] & ~inhibit & ~i_overtravel_limit_rev;
    next_r.test_stop  = r.st[1] & (inhibit | i_overtravel_limit_fwd | i_overtravel_limit_rev);
    next_r.blank      = 3'h0;
    next_r.mark       = KPE_MK_NONE;
    case (r.st)
      KPE_EDIT, KPE_STORE: begin
        if (!split) begin
          next_r.disp = {r.dig[2], r.dig[1], r.dig[0]};
          next_r.mark = (r.sgn & r.neg) ? KPE_MK_MINUS : KPE_MK_NONE;
        end else if (r.upper) begin
          next_r.disp = {r.dig[4], r.dig[3], r.dig[2]};
          next_r.mark = (r.sgn & r.neg) ? KPE_MK_MINUS : KPE_MK_H;
        end else begin
          next_r.disp = {r.dig[2], r.dig[1], r.dig[0]};
          next_r.mark = KPE_MK_L;
        end
        if (r.st == KPE_STORE) begin
          next_r.blank = r.st_ph[0] ? 3'h7 : 3'h0;
        end else begin
          next_r.blank = r.blk_ph ? 3'(3'h1 << r.sel) : 3'h0;
        end
      end
      KPE_PSEL: begin
        next_r.disp = {4'h0, 4'(r.pnum / 7'd10), 4'(r.pnum % 7'd10)};
      end
      default: begin
        next_r.disp = {8'h00, r.fn};
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r    <= '0;
      r.fn <= FN_FEED;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_disp_digits          = r.disp;
  assign o_disp_marker          = r.mark;
  assign o_blink_mask           = r.blank;
  assign o_rejection_indication = r.rej;
  assign o_param_num            = r.pnum;
  assign o_fn_num               = r.fn;
  assign o_wr_stb               = r.wr_stb;
  assign o_wr_addr              = r.wr_addr;
  assign o_wr_data              = r.wr_data;
  assign o_feed_fwd             = r.feed_fwd;
  assign o_feed_rev             = r.feed_rev;
  assign o_feed_speed           = r.feed_speed;
  assign o_test_stop            = r.test_stop;
  assign o_cmd_pos_clr          = r.pos_clr;
  assign o_fb_pos_clr           = r.pos_clr;
  assign o_cmd_cum_clr          = r.cum_clr;
  assign o_fb_cum_clr           = r.cum_clr;
  assign o_alarm                = r.alarm;
  assign o_hist_erase           = r.hist_erase;
  assign o_param_init           = r.param_init;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  a_up_wrap: assert property (
    (r.st == KPE_EDIT && !i_test_mode && press[K_UP] && !press[K_ESC] && !lp_evt && r.dig[didx] == 4'h9)
    |=> r.dig[$past(didx)] == 4'h0 && r.dig[4] == $past(r.dig[4]) | ($past(didx) == 3'h4))
    else $error("digit up from nine did not give zero");
  a_dn_wrap: assert property (
    (r.st == KPE_EDIT && !i_test_mode && !press[K_UP] && press[K_DN] && !press[K_ESC] && !lp_evt
     && r.dig[didx] == 4'h0) |=> r.dig[$past(didx)] == 4'h9)
    else $error("digit down from zero did not give nine");
  a_open_right: assert property (
    (r.st == KPE_PSEL && !i_test_mode && lp_evt && !press[K_UP] && !press[K_DN])
    |=> r.st == KPE_EDIT && r.sel == 2'h0 && r.upper == (r.ndig > HALF_DIGITS) ##1 o_blink_mask == 3'h0)
    else $error("edit did not open on rightmost digit");
  a_shift_hold: assert property (
    (r.st == KPE_EDIT && press == 5'h04 && !lp_evt) |=> r.dig == $past(r.dig))
    else $error("shift changed the value");
  a_store_long: assert property (
    (r.wr_stb && r.st == KPE_STORE) |-> $past(lp_evt) && $past(r.st) == KPE_EDIT)
    else $error("store without long enter");
  a_esc_exit: assert property (
    (r.st == KPE_EDIT && !i_test_mode && press[K_ESC]) |=> r.st == KPE_PSEL && !r.wr_stb)
    else $error("escape did not leave edit");
  a_range_rej: assert property (
    (r.st == KPE_EDIT && !i_test_mode && lp_evt && !in_rng && !press[K_ESC])
    |=> r.rej && !r.wr_stb && r.st == KPE_EDIT)
    else $error("out of range value applied");
  a_sign_mark: assert property (
    (r.st == KPE_EDIT && split && r.upper && r.sgn && r.neg) |=> o_disp_marker == KPE_MK_MINUS)
    else $error("negative upper half lacks minus marker");
  a_unsigned_mark: assert property (
    (r.st == KPE_EDIT && split && !r.sgn) |=> o_disp_marker == ($past(r.upper) ? KPE_MK_H : KPE_MK_L))
    else $error("unsigned split marker wrong");
  a_exec_long: assert property (
    (r.pos_clr || r.cum_clr || r.param_init || r.hist_erase) |-> $past(lp_evt) && $past(r.st) == KPE_TMENU)
    else $error("test function ran without long enter");
  a_feed_release: assert property (
    (!r.key[K_UP] && !r.key[K_DN]) |=> !o_feed_fwd && !o_feed_rev)
    else $error("feed continued after key release");
  a_interlock: assert property (
    (r.st == KPE_TMENU && i_test_mode && lp_evt && busy && r.fn >= FN_FEED && r.fn <= FN_CUM)
    |=> r.rej && !r.pos_clr && !r.cum_clr && r.st != KPE_FEED)
    else $error("interlocked function was not refused");
  a_ot_block: assert property (
    (i_overtravel_limit_fwd || i_forced_stop || i_coast) |=> !o_feed_fwd)
    else $error("feed ignored a stop input");
  a_pos_pulse: assert property (
    r.pos_clr |=> !r.pos_clr)
    else $error("position reset not a single pulse");
  a_alarm_clr: assert property (
    (r.st == KPE_TMENU && i_test_mode && lp_evt && r.fn == FN_ALM)
    |=> (r.alarm & ALM_RESET_MASK) == ($past(i_alarm_evt) & ALM_RESET_MASK))
    else $error("resettable alarm survived reset");
  a_alarm_keep: assert property (
    1'b1 |=> (r.alarm & ~ALM_RESET_MASK) == (($past(r.alarm) | $past(i_alarm_evt)) & ~ALM_RESET_MASK))
    else $error("power-only alarm cleared");
  a_pinit_lock: assert property (
    (r.st == KPE_TMENU && i_test_mode && lp_evt && r.fn == FN_PINIT && (i_run || i_write_protect))
    |=> r.rej && !r.param_init)
    else $error("parameter init not refused");
  a_ofs_write: assert property (
    (r.st == KPE_TMENU && i_test_mode && lp_evt && r.fn == FN_OFS)
    |=> r.wr_stb == !$past(i_write_protect) && r.wr_addr == PARAM_OFS)
    else $error("offset write wrong");

endmodule

//--- hw/kpe_pkg.sv
// keypad parameter editing and test-running package: states, keys, codes, timing
// assumes one 100 MHz clock; times below are in their own units
package kpe_pkg;

  // ****************************************
  // states and display markers
  // ****************************************
  typedef enum logic [2:0] {
    KPE_PSEL  = 3'b000,
    KPE_EDIT  = 3'b001,
    KPE_STORE = 3'b011,
    KPE_TMENU = 3'b010,
    KPE_FEED  = 3'b110
  } kpe_state_t;

  typedef enum logic [1:0] {
    KPE_MK_NONE  = 2'h0,
    KPE_MK_H     = 2'h1,
    KPE_MK_L     = 2'h2,
    KPE_MK_MINUS = 2'h3
  } kpe_marker_t;

  // ****************************************
  // keys, functions, parameter numbers
  // ****************************************
  localparam int K_UP  = 0;
  localparam int K_DN  = 1;
  localparam int K_SH  = 2;
  localparam int K_ENT = 3;
  localparam int K_ESC = 4;

  localparam logic [3:0] FN_FEED  = 4'h1;
  localparam logic [3:0] FN_POS   = 4'h2;
  localparam logic [3:0] FN_CUM   = 4'h3;
  localparam logic [3:0] FN_ALM   = 4'h4;
  localparam logic [3:0] FN_HIST  = 4'h5;
  localparam logic [3:0] FN_PINIT = 4'h6;
  localparam logic [3:0] FN_OFS   = 4'h7;
  localparam logic [3:0] FN_ZADJ  = 4'h8;

  localparam logic [6:0] PARAM_ZOFS  = 7'h14;
  localparam logic [6:0] PARAM_OFS   = 7'h47;
  localparam logic [6:0] PARAM_LAST  = 7'h63;
  localparam logic [3:0] DIGIT_MAX   = 4'h9;
  localparam logic [2:0] HALF_DIGITS = 3'h3;
  localparam logic [2:0] STORE_PHASES = 3'h5;

  // bits 0..10 resettable, 11..14 cleared only by power-on
  localparam logic [14:0] ALM_RESET_MASK = 15'h07ff;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 100;
  localparam int KEY_DEB_US     = 10000;
  localparam int LONG_PRESS_MS  = 1000;
  localparam int EDIT_BLINK_MS  = 1000;
  localparam int STORE_BLINK_MS = 500;
  localparam int DEB_CYC        = KEY_DEB_US * CLK_MHZ;
  localparam int LONG_CYC       = LONG_PRESS_MS * 1000 * CLK_MHZ;
  localparam int EDIT_HALF_CYC  = EDIT_BLINK_MS * 1000 * CLK_MHZ / 2;
  localparam int STORE_HALF_CYC = STORE_BLINK_MS * 1000 * CLK_MHZ / 2;

endpackage

//--- bench/kpe_core_model.sv
// partner model: parameter store and servo core status seen by the keypad block
// assumes one-cycle write strobes from the block on i_core_clk
`timescale 1ns/100ps
module kpe_core_model (
  // clock and scenario control
  input  wire logic               i_core_clk,
  input  wire logic               i_tight,
  // parameter write from the block
  input  wire logic               o_wr_stb,
  input  wire logic [17:0]        o_wr_data,
  // parameter store and core values
  output logic [19:0]             i_param_bcd,
  output logic                    i_param_neg,
  output logic [2:0]              i_param_digits,
  output logic                    i_param_signed,
  output logic signed [17:0]      i_range_min,
  output logic signed [17:0]      i_range_max,
  output logic [15:0]             i_feed_speed,
  output logic [15:0]             i_vref_offset,
  output logic [17:0]             i_z_distance,
  // captured writes
  output logic [7:0]              o_wr_cnt = 8'h00,
  output logic [17:0]             o_last_data = 18'h00000
);
  assign i_param_bcd    = 20'h12999;
  assign i_param_neg    = i_tight;
  assign i_param_digits = 3'h5;
  assign i_param_signed = i_tight;
  assign i_range_min    = 18'sh00000;
  assign i_range_max    = i_tight ? 18'sh00064 : 18'sh07fff;
  assign i_feed_speed   = 16'h0123;
  assign i_vref_offset  = 16'h0000;
  assign i_z_distance   = 18'h00155;
  always_ff @(posedge i_core_clk) begin
    if (o_wr_stb) begin
      o_wr_cnt    <= o_wr_cnt + 8'h01;
      o_last_data <= o_wr_data;
    end
  end
endmodule

//--- bench/kpe_top_tb.sv
// testbench: edits a split parameter, stores it, runs manual feed and the test functions
// assumes small debounce and long-press counts set below
`timescale 1ns/100ps
module kpe_top_tb;
  import kpe_pkg::*;
  logic i_core_clk = 0, i_rst_b = 0, i_test_mode = 0, i_write_protect = 0, i_tight = 0, i_run = 0;
  logic i_forward_run_command = 0, i_reverse_run_command = 0, i_motor_rotating = 0, i_forced_stop = 0;
  logic i_regen_overheat = 0, i_overtravel_limit_fwd = 0, i_overtravel_limit_rev = 0, i_coast = 0;
  logic [4:0] keys = 5'h00;
  logic [14:0] i_alarm_evt = 15'h0000;
  wire logic i_key_up = keys[K_UP], i_key_down = keys[K_DN], i_key_shift = keys[K_SH];
  wire logic i_key_enter = keys[K_ENT], i_key_esc = keys[K_ESC];
  logic [19:0] i_param_bcd;
  logic i_param_neg, i_param_signed, o_wr_stb, o_rejection_indication, o_feed_fwd;
  logic [2:0] i_param_digits, o_blink_mask;
  logic signed [17:0] i_range_min, i_range_max;
  logic [15:0] i_feed_speed, i_vref_offset, o_feed_speed;
  logic [17:0] i_z_distance, o_wr_data, o_last_data;
  logic [11:0] o_disp_digits;
  logic [1:0] o_disp_marker;
  logic [7:0] o_wr_cnt;
  logic [3:0] o_fn_num;
  logic [6:0] o_param_num, o_wr_addr;
  logic [14:0] o_alarm;
  logic o_feed_rev, o_test_stop, o_cmd_pos_clr, o_fb_pos_clr, o_cmd_cum_clr, o_fb_cum_clr;
  logic o_hist_erase, o_param_init;
  logic [7:0] seen = 8'h00;
  logic [2:0] blinks = 3'h0;
  int err_count = 0, cmp_count = 0;
  kpe_top #(.P_DEB_CYC(4), .P_LONG_CYC(20), .P_BLINK_CYC(8), .P_STORE_CYC(4)) DUT (.*);
  kpe_core_model u_model (.*);
  initial forever #5 i_core_clk = ~i_core_clk;
  // sticky record of pulses and blink masks, sampled where settled
  always @(negedge i_core_clk) begin
    seen   <= seen | {o_param_init, o_hist_erase, o_fb_cum_clr, o_cmd_cum_clr,
                      o_fb_pos_clr, o_cmd_pos_clr, o_test_stop, o_feed_rev};
    blinks <= blinks | o_blink_mask;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task key(input int k, input int n);
    keys[k] <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    keys[k] <= 1'b0;
    repeat (40) @(posedge i_core_clk);
  endtask
  task stop_test;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_edit;
    key(K_UP, 8);
    chk(o_param_num, 7'h01);
    key(K_ENT, 32);
    chk(o_disp_digits, 12'h129);
    chk(o_disp_marker, KPE_MK_H);
    chk(blinks, 3'h1);
    key(K_UP, 8);
    chk(o_disp_digits, 12'h120);
    key(K_SH, 8);
    key(K_UP, 8);
    chk(o_disp_digits, 12'h130);
    key(K_ENT, 32);
    chk(o_wr_cnt, 8'h01);
    chk(o_last_data, 18'd13099);
    chk(o_wr_addr, 7'h01);
    chk(blinks, 3'h7);
    i_tight <= 1'b1;
    key(K_ENT, 32);
    chk(o_rejection_indication, 1'b1);
    chk(o_wr_cnt, 8'h01);
    key(K_ESC, 8);
    chk(o_disp_digits, 12'h001);
    key(K_ENT, 32);
    chk(o_disp_marker, KPE_MK_MINUS);
    repeat (3) key(K_SH, 8);
    chk(o_disp_marker, KPE_MK_L);
    key(K_ESC, 8);
    $display("test edit done");
  endtask
  task t_feed;
    i_test_mode <= 1'b1;
    i_motor_rotating <= 1'b1;
    key(K_ENT, 32);
    chk(o_rejection_indication, 1'b1);
    i_motor_rotating <= 1'b0;
    key(K_ENT, 32);
    keys[K_UP] <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    chk(o_feed_fwd, 1'b1);
    chk(o_feed_speed, 16'h0123);
    i_forced_stop <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk(o_feed_fwd, 1'b0);
    i_forced_stop <= 1'b0;
    keys[K_UP] <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    chk(o_feed_fwd, 1'b0);
    key(K_DN, 10);
    chk(seen, 8'h03);
    key(K_ESC, 8);
    $display("test feed done");
  endtask
  task t_fns;
    i_alarm_evt <= 15'h7fff;
    @(posedge i_core_clk);
    i_alarm_evt <= 15'h0000;
    key(K_UP, 8);
    chk(o_fn_num, 4'h2);
    key(K_ENT, 8);
    chk(seen, 8'h03);
    key(K_ENT, 32);
    chk(seen, 8'h0f);
    key(K_UP, 8);
    key(K_ENT, 32);
    chk(seen, 8'h3f);
    key(K_UP, 8);
    chk(o_alarm, 15'h7fff);
    key(K_ENT, 32);
    chk(o_alarm, 15'h7800);
    key(K_UP, 8);
    key(K_ENT, 32);
    chk(seen, 8'h7f);
    key(K_UP, 8);
    i_write_protect <= 1'b1;
    key(K_ENT, 32);
    chk(o_rejection_indication, 1'b1);
    chk(seen, 8'h7f);
    i_write_protect <= 1'b0;
    key(K_ENT, 32);
    chk(seen, 8'hff);
    key(K_UP, 8);
    key(K_ENT, 32);
    chk(o_wr_addr, 7'h47);
    chk(o_wr_cnt, 8'h02);
    key(K_UP, 8);
    key(K_ENT, 32);
    chk(o_wr_addr, 7'h14);
    chk(o_last_data, 18'h00155);
    $display("test functions done");
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk(o_fn_num, 4'h1);
    t_edit;
    t_feed;
    t_fns;
    stop_test;
  end
  initial begin
    repeat (6000) @(posedge i_core_clk);
    err_count++;
    stop_test;
  end
endmodule
